// File: rtl/ocd_decoder.sv
// opcode decode, length, effective address and cycle count for the 8-bit core
// How it works
// - direct: low address is byte after opcode, high zero, counter plus two
// - extended: two following bytes give high then low address, counter plus three
// - indexed no offset: address is index register, high zero, one byte
// - register/memory upper nibble A..F picks immediate..indexed no offset
// - lower nibbles 0..7: sub, cmp, sbc, cpx, and, bit, load, store
// - lower nibbles 8..F: eor, adc, or, add, jump, jsr, load x, store x
// - loads/alu take 2,3,4,3,4,5 cycles per mode
// - stores one more, no immediate; jump one less; jsr 5,6,5,6,7
// - modify/write upper nibble 4 A, 5 X, 3 direct, 7 ix0, 6 ix1
// - modify/write lower nibble picks neg, com, shifts, rotates, dec, inc, tst, clr
// - modify/write 3 register, 5 memory, 6 ix1; test one less on memory
// - branches 20..2F, two bytes, three cycles, condition pairs
// - 2C/2D test interrupt mask, 2E/2F test interrupt line
// - branch to subroutine AD, two bytes, six cycles
// - test-and-branch 2n set, 01+2n clear, three bytes, five cycles
// - bit set 10+2n, bit clear 11+2n, two bytes, five cycles
// - one-byte two-cycle control opcodes 97,9F,99,98,9B,9A,9C,9D
// - swi 83 ten cycles, rts 81 six, rti 80 nine
// - test-and-branch copies the tested bit into carry
`timescale 1ns/10ps
module ocd_decoder
  import ocd_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic DECODE_IN,
  input wire logic [7:0] OPCODE_IN,
  input wire logic [7:0] BYTE1_IN,
  input wire logic [7:0] BYTE2_IN,
  input wire logic [7:0] INDEX_IN,
  input wire logic [15:0] PROGRAM_COUNTER_IN,
  input wire logic [7:0] TESTED_BYTE_IN,
  output logic VALID_OUT,
  output ocd_group_type GROUP_OUT,
  output ocd_mode_type MODE_OUT,
  output ocd_op_type OP_OUT,
  output logic [1:0] LENGTH_OUT,
  output logic [3:0] CYCLES_OUT,
  output logic [15:0] EFFECTIVE_ADDRESS_OUT,
  output logic [15:0] NEXT_PROGRAM_COUNTER_OUT,
  output logic [7:0] BRANCH_OFFSET_OUT,
  output logic [3:0] BRANCH_COND_OUT,
  output logic [2:0] BIT_NUM_OUT,
  output logic CARRY_FROM_BIT_OUT,
  output logic WRITE_BACK_OUT,
  output logic UNDEFINED_OUT
);
  logic [3:0] hi_nib;
  logic [3:0] lo_nib;
  ocd_op_type regmem_op;
  ocd_op_type rmw_op;
  ocd_group_type grp;
  ocd_mode_type mode;
  ocd_op_type op;
  logic [1:0] len;
  logic [3:0] cyc;
  logic [15:0] ea;
  logic wb;
  logic [7:0] rel_off;

  ////////////////////////////////////////////////////////////////////////////
  assign hi_nib = OPCODE_IN[7:4];
  assign lo_nib = OPCODE_IN[3:0];

  ocd_regmem_table u_table (
    .lo_nib_in(lo_nib),
    .regmem_op_out(regmem_op),
    .rmw_op_out(rmw_op)
  );

  ocd_addr_former u_addr (
    .mode_in(mode),
    .byte1_in(BYTE1_IN),
    .byte2_in(BYTE2_IN),
    .index_in(INDEX_IN),
    .addr_out(ea)
  );

  ////////////////////////////////////////////////////////////////////////////
  // group, mode, operation and length from the opcode byte
  always_comb begin
    grp = OCD_GRP_UNDEF;
    mode = OCD_MODE_INH;
    op = OCD_OP_UNDEF;
    len = OCD_LEN_1;
    if (OPCODE_IN == OCD_OPC_BSR) begin
      grp = OCD_GRP_BRANCH;
      mode = OCD_MODE_REL;
      op = OCD_OP_BSR;
      len = OCD_LEN_2;
    end else if (hi_nib >= OCD_HI_IMM) begin
      grp = OCD_GRP_REGMEM;
      op = regmem_op;
      case (hi_nib)
        OCD_HI_IMM: begin
          mode = OCD_MODE_IMM;
          len = OCD_LEN_2;
        end
        OCD_HI_DIR: begin
          mode = OCD_MODE_DIR;
          len = OCD_LEN_2;
        end
        OCD_HI_EXT: begin
          mode = OCD_MODE_EXT;
          len = OCD_LEN_3;
        end
        OCD_HI_IX2: begin
          mode = OCD_MODE_IX2;
          len = OCD_LEN_3;
        end
        OCD_HI_IX1: begin
          mode = OCD_MODE_IX1;
          len = OCD_LEN_2;
        end
        default: begin
          mode = OCD_MODE_IX0;
          len = OCD_LEN_1;
        end
      endcase
      // no immediate store or jumps: A7, AF and AC are undefined; AD is taken above as bsr
      if (hi_nib == OCD_HI_IMM && (regmem_op == OCD_OP_STA || regmem_op == OCD_OP_STX ||
          regmem_op == OCD_OP_JMP || regmem_op == OCD_OP_JSR)) begin
        grp = OCD_GRP_UNDEF;
        mode = OCD_MODE_INH;
        op = OCD_OP_UNDEF;
        len = OCD_LEN_1;
      end
    end else if (hi_nib >= OCD_HI_RMW_DIR && hi_nib <= OCD_HI_RMW_IX0) begin
      if (rmw_op != OCD_OP_UNDEF) begin
        grp = OCD_GRP_RMW;
        op = rmw_op;
        case (hi_nib)
          OCD_HI_RMW_A: mode = OCD_MODE_INHA;
          OCD_HI_RMW_X: mode = OCD_MODE_INHX;
          OCD_HI_RMW_DIR: mode = OCD_MODE_DIR;
          OCD_HI_RMW_IX0: mode = OCD_MODE_IX0;
          default: mode = OCD_MODE_IX1;
        endcase
        if (hi_nib == OCD_HI_RMW_DIR || hi_nib == OCD_HI_RMW_IX1) begin
          len = OCD_LEN_2;
        end
      end
    end else if (hi_nib == OCD_HI_BRANCH) begin
      grp = OCD_GRP_BRANCH;
      mode = OCD_MODE_REL;
      op = OCD_OP_BRANCH;
      len = OCD_LEN_2;
    end else if (hi_nib == OCD_HI_BSC) begin
      grp = OCD_GRP_BITSC;
      mode = OCD_MODE_BSC;
      op = lo_nib[0] ? OCD_OP_CLEAR_BIT_OP : OCD_OP_SET_BIT_OP;
      len = OCD_LEN_2;
    end else if (hi_nib == OCD_HI_BTB) begin
      grp = OCD_GRP_BITTB;
      mode = OCD_MODE_BTB;
      op = lo_nib[0] ? OCD_OP_BRANCH_IF_BIT_CLEAR : OCD_OP_BRANCH_IF_BIT_SET;
      len = OCD_LEN_3;
    end else begin
      case (OPCODE_IN)
        OCD_OPC_TAX: op = OCD_OP_TAX;
        OCD_OPC_TXA: op = OCD_OP_TXA;
        OCD_OPC_SEC: op = OCD_OP_SEC;
        OCD_OPC_CLC: op = OCD_OP_CLC;
        OCD_OPC_SEI: op = OCD_OP_SEI;
        OCD_OPC_CLI: op = OCD_OP_CLI;
        OCD_OPC_RSP: op = OCD_OP_RSP;
        OCD_OPC_NOP: op = OCD_OP_NOP;
        OCD_OPC_SWI: op = OCD_OP_SWI;
        OCD_OPC_RTS: op = OCD_OP_RTS;
        OCD_OPC_RTI: op = OCD_OP_RTI;
        OCD_OPC_STOP: op = OCD_OP_STOP;
        OCD_OPC_WAIT: op = OCD_OP_WAIT;
        default: op = OCD_OP_UNDEF;
      endcase
      if (op != OCD_OP_UNDEF) begin
        grp = OCD_GRP_CTRL;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cycle count; in register/memory, loads form the base, store, jump and jsr are offsets from it
  always_comb begin
    cyc = OCD_CYC_UNDEF;
    wb = 1'b0;
    case (grp)
      OCD_GRP_REGMEM: begin
        case (mode)
          OCD_MODE_IMM: cyc = OCD_CYC_LD_IMM;
          OCD_MODE_DIR: cyc = OCD_CYC_LD_DIR;
          OCD_MODE_EXT: cyc = OCD_CYC_LD_EXT;
          OCD_MODE_IX0: cyc = OCD_CYC_LD_IX0;
          OCD_MODE_IX1: cyc = OCD_CYC_LD_IX1;
          default: cyc = OCD_CYC_LD_IX2;
        endcase
        if (op == OCD_OP_STA || op == OCD_OP_STX) begin
          cyc = 4'(cyc + 4'h1);
          wb = 1'b1;
        end else if (op == OCD_OP_JMP) begin
          cyc = 4'(cyc - 4'h1);
        end else if (op == OCD_OP_JSR) begin
          cyc = 4'(cyc + OCD_CYC_JSR_EXTRA);
        end
      end
      OCD_GRP_RMW: begin
        case (mode)
          OCD_MODE_INHA, OCD_MODE_INHX: cyc = OCD_CYC_RMW_REG;
          OCD_MODE_IX1: cyc = OCD_CYC_RMW_IX1;
          default: cyc = OCD_CYC_RMW_MEM;
        endcase
        // test reads only: memory forms lose the write cycle
        if (op == OCD_OP_TST) begin
          if (mode != OCD_MODE_INHA && mode != OCD_MODE_INHX) begin
            cyc = 4'(cyc - 4'h1);
          end
        end else begin
          wb = 1'b1;
        end
      end
      OCD_GRP_BRANCH: cyc = (op == OCD_OP_BSR) ? OCD_CYC_BSR : OCD_CYC_BRANCH;
      OCD_GRP_BITSC: begin
        cyc = OCD_CYC_BIT;
        wb = 1'b1;
      end
      OCD_GRP_BITTB: cyc = OCD_CYC_BIT;
      OCD_GRP_CTRL: begin
        case (op)
          OCD_OP_SWI: cyc = OCD_CYC_SWI;
          OCD_OP_RTS: cyc = OCD_CYC_RTS;
          OCD_OP_RTI: cyc = OCD_CYC_RTI;
          default: cyc = OCD_CYC_CTRL;
        endcase
      end
      default: cyc = OCD_CYC_UNDEF;
    endcase
  end

  // relative offset: second byte for branches, third for test-and-branch
  assign rel_off = (grp == OCD_GRP_BITTB) ? BYTE2_IN : BYTE1_IN;

  ////////////////////////////////////////////////////////////////////////////
  // result registers, loaded on each decode request
  logic valid_q, valid_d;
  ocd_group_type grp_q, grp_d;
  ocd_mode_type mode_q, mode_d;
  ocd_op_type op_q, op_d;
  logic [1:0] len_q, len_d;
  logic [3:0] cyc_q, cyc_d;
  logic [15:0] ea_q, ea_d;
  logic [15:0] npc_q, npc_d;
  logic [7:0] off_q, off_d;
  logic [3:0] cond_q, cond_d;
  logic [2:0] bitn_q, bitn_d;
  logic carry_q, carry_d;
  logic wb_q, wb_d;

  always_comb begin
    valid_d = DECODE_IN;
    grp_d = grp_q;
    mode_d = mode_q;
    op_d = op_q;
    len_d = len_q;
    cyc_d = cyc_q;
    ea_d = ea_q;
    npc_d = npc_q;
    off_d = off_q;
    cond_d = cond_q;
    bitn_d = bitn_q;
    carry_d = carry_q;
    wb_d = wb_q;
    if (DECODE_IN) begin
      grp_d = grp;
      mode_d = mode;
      op_d = op;
      len_d = len;
      cyc_d = cyc;
      ea_d = ea;
      npc_d = 16'(PROGRAM_COUNTER_IN + {14'h0000, len});
      off_d = rel_off;
      cond_d = lo_nib;
      bitn_d = lo_nib[3:1];
      carry_d = TESTED_BYTE_IN[lo_nib[3:1]];
      wb_d = wb;
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      valid_q <= 1'b0;
      grp_q <= OCD_GRP_UNDEF;
      mode_q <= OCD_MODE_INH;
      op_q <= OCD_OP_UNDEF;
      len_q <= OCD_LEN_1;
      cyc_q <= OCD_CYC_UNDEF;
      ea_q <= 16'h0000;
      npc_q <= 16'h0000;
      off_q <= 8'h00;
      cond_q <= 4'h0;
      bitn_q <= 3'h0;
      carry_q <= 1'b0;
      wb_q <= 1'b0;
    end else begin
      valid_q <= valid_d;
      grp_q <= grp_d;
      mode_q <= mode_d;
      op_q <= op_d;
      len_q <= len_d;
      cyc_q <= cyc_d;
      ea_q <= ea_d;
      npc_q <= npc_d;
      off_q <= off_d;
      cond_q <= cond_d;
      bitn_q <= bitn_d;
      carry_q <= carry_d;
      wb_q <= wb_d;
    end
  end

  assign VALID_OUT = valid_q;
  assign GROUP_OUT = grp_q;
  assign MODE_OUT = mode_q;
  assign OP_OUT = op_q;
  assign LENGTH_OUT = len_q;
  assign CYCLES_OUT = cyc_q;
  assign EFFECTIVE_ADDRESS_OUT = ea_q;
  assign NEXT_PROGRAM_COUNTER_OUT = npc_q;
  assign BRANCH_OFFSET_OUT = off_q;
  assign BRANCH_COND_OUT = cond_q;
  assign BIT_NUM_OUT = bitn_q;
  // carry copy only means something for test-and-branch
  assign CARRY_FROM_BIT_OUT = carry_q & (grp_q == OCD_GRP_BITTB);
  assign WRITE_BACK_OUT = wb_q;
  assign UNDEFINED_OUT = (grp_q == OCD_GRP_UNDEF);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_direct_addr: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (DECODE_IN && OPCODE_IN[7:4] == OCD_HI_DIR) |=>
      (EFFECTIVE_ADDRESS_OUT == {8'h00, $past(BYTE1_IN)} &&
       NEXT_PROGRAM_COUNTER_OUT == 16'($past(PROGRAM_COUNTER_IN) + 16'h0002)))
    else $error("direct address or counter wrong");
  chk_extended_addr: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (DECODE_IN && OPCODE_IN[7:4] == OCD_HI_EXT) |=>
      (EFFECTIVE_ADDRESS_OUT == {$past(BYTE1_IN), $past(BYTE2_IN)} && LENGTH_OUT == 2'h3))
    else $error("extended address wrong");
  chk_index_addr: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (DECODE_IN && OPCODE_IN[7:4] == OCD_HI_IX0) |=>
      (EFFECTIVE_ADDRESS_OUT == {8'h00, $past(INDEX_IN)} && LENGTH_OUT == 2'h1))
    else $error("indexed no-offset address wrong");
  chk_load_cycles: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (DECODE_IN && OPCODE_IN == 8'hD6) |=> (CYCLES_OUT == 4'h5 && OP_OUT == OCD_OP_LDA))
    else $error("indexed 16-bit load timing wrong");
  chk_jsr_cycles: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (DECODE_IN && OPCODE_IN == 8'hDD) |=> (CYCLES_OUT == 4'h7))
    else $error("jump to subroutine timing wrong");
  chk_tst_cycles: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (DECODE_IN && OPCODE_IN == 8'h6D) |=> (CYCLES_OUT == 4'h5 && !WRITE_BACK_OUT))
    else $error("test timing or write-back wrong");
  chk_swi_cycles: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (DECODE_IN && OPCODE_IN == OCD_OPC_SWI) |=> (CYCLES_OUT == 4'hA && LENGTH_OUT == 2'h1))
    else $error("software interrupt timing wrong");
  chk_bit_carry: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (DECODE_IN && OPCODE_IN[7:4] == OCD_HI_BTB) |=>
      (CARRY_FROM_BIT_OUT == $past(TESTED_BYTE_IN[OPCODE_IN[3:1]]) && CYCLES_OUT == 4'h5))
    else $error("tested bit not copied to carry");
endmodule

// File: rtl/ocd_pkg.sv
// package: opcode classes, operation codes, mode codes, cycle figures for the decoder
package ocd_pkg;
  typedef enum logic [2:0] {
    OCD_GRP_REGMEM, OCD_GRP_RMW, OCD_GRP_BRANCH, OCD_GRP_BITSC, OCD_GRP_BITTB,
    OCD_GRP_CTRL, OCD_GRP_UNDEF
  } ocd_group_type;
  typedef enum logic [3:0] {
    OCD_MODE_INH, OCD_MODE_IMM, OCD_MODE_DIR, OCD_MODE_EXT, OCD_MODE_IX0, OCD_MODE_IX1,
    OCD_MODE_IX2, OCD_MODE_REL, OCD_MODE_BSC, OCD_MODE_BTB, OCD_MODE_INHA, OCD_MODE_INHX
  } ocd_mode_type;
  typedef enum logic [5:0] {
    OCD_OP_SUB, OCD_OP_CMPA, OCD_OP_SBC, OCD_OP_CMPX, OCD_OP_AND, OCD_OP_BIT,
    OCD_OP_LDA, OCD_OP_STA, OCD_OP_EOR, OCD_OP_ADC, OCD_OP_ORA, OCD_OP_ADD,
    OCD_OP_JMP, OCD_OP_JSR, OCD_OP_LDX, OCD_OP_STX,
    OCD_OP_NEG, OCD_OP_COM, OCD_OP_LSR, OCD_OP_ROR, OCD_OP_ASR, OCD_OP_LSL,
    OCD_OP_ROL, OCD_OP_DEC, OCD_OP_INC, OCD_OP_TST, OCD_OP_CLR,
    OCD_OP_BRANCH, OCD_OP_BSR, OCD_OP_BRANCH_IF_BIT_SET, OCD_OP_BRANCH_IF_BIT_CLEAR, OCD_OP_SET_BIT_OP, OCD_OP_CLEAR_BIT_OP,
    OCD_OP_TAX, OCD_OP_TXA, OCD_OP_SEC, OCD_OP_CLC, OCD_OP_SEI, OCD_OP_CLI,
    OCD_OP_RSP, OCD_OP_NOP, OCD_OP_SWI, OCD_OP_RTS, OCD_OP_RTI, OCD_OP_STOP,
    OCD_OP_WAIT, OCD_OP_UNDEF
  } ocd_op_type;
  // register/memory upper nibbles
  localparam logic [3:0] OCD_HI_IMM = 4'hA;
  localparam logic [3:0] OCD_HI_DIR = 4'hB;
  localparam logic [3:0] OCD_HI_EXT = 4'hC;
  localparam logic [3:0] OCD_HI_IX2 = 4'hD;
  localparam logic [3:0] OCD_HI_IX1 = 4'hE;
  localparam logic [3:0] OCD_HI_IX0 = 4'hF;
  // read/modify/write upper nibbles
  localparam logic [3:0] OCD_HI_RMW_DIR = 4'h3;
  localparam logic [3:0] OCD_HI_RMW_A = 4'h4;
  localparam logic [3:0] OCD_HI_RMW_X = 4'h5;
  localparam logic [3:0] OCD_HI_RMW_IX1 = 4'h6;
  localparam logic [3:0] OCD_HI_RMW_IX0 = 4'h7;
  localparam logic [3:0] OCD_HI_BTB = 4'h0;
  localparam logic [3:0] OCD_HI_BSC = 4'h1;
  localparam logic [3:0] OCD_HI_BRANCH = 4'h2;
  localparam logic [7:0] OCD_OPC_BSR = 8'hAD;
  localparam logic [7:0] OCD_OPC_RTI = 8'h80;
  localparam logic [7:0] OCD_OPC_RTS = 8'h81;
  localparam logic [7:0] OCD_OPC_SWI = 8'h83;
  localparam logic [7:0] OCD_OPC_STOP = 8'h8E;
  localparam logic [7:0] OCD_OPC_WAIT = 8'h8F;
  localparam logic [7:0] OCD_OPC_TAX = 8'h97;
  localparam logic [7:0] OCD_OPC_CLC = 8'h98;
  localparam logic [7:0] OCD_OPC_SEC = 8'h99;
  localparam logic [7:0] OCD_OPC_CLI = 8'h9A;
  localparam logic [7:0] OCD_OPC_SEI = 8'h9B;
  localparam logic [7:0] OCD_OPC_RSP = 8'h9C;
  localparam logic [7:0] OCD_OPC_NOP = 8'h9D;
  localparam logic [7:0] OCD_OPC_TXA = 8'h9F;
  // cycle figures (instruction cycles)
  localparam logic [3:0] OCD_CYC_LD_IMM = 4'h2;
  localparam logic [3:0] OCD_CYC_LD_DIR = 4'h3;
  localparam logic [3:0] OCD_CYC_LD_EXT = 4'h4;
  localparam logic [3:0] OCD_CYC_LD_IX0 = 4'h3;
  localparam logic [3:0] OCD_CYC_LD_IX1 = 4'h4;
  localparam logic [3:0] OCD_CYC_LD_IX2 = 4'h5;
  localparam logic [3:0] OCD_CYC_JSR_EXTRA = 4'h2;
  localparam logic [3:0] OCD_CYC_RMW_REG = 4'h3;
  localparam logic [3:0] OCD_CYC_RMW_MEM = 4'h5;
  localparam logic [3:0] OCD_CYC_RMW_IX1 = 4'h6;
  localparam logic [3:0] OCD_CYC_BRANCH = 4'h3;
  localparam logic [3:0] OCD_CYC_BSR = 4'h6;
  localparam logic [3:0] OCD_CYC_BIT = 4'h5;
  localparam logic [3:0] OCD_CYC_CTRL = 4'h2;
  localparam logic [3:0] OCD_CYC_SWI = 4'hA;
  localparam logic [3:0] OCD_CYC_RTS = 4'h6;
  localparam logic [3:0] OCD_CYC_RTI = 4'h9;
  localparam logic [3:0] OCD_CYC_UNDEF = 4'h2;
  localparam logic [1:0] OCD_LEN_1 = 2'h1;
  localparam logic [1:0] OCD_LEN_2 = 2'h2;
  localparam logic [1:0] OCD_LEN_3 = 2'h3;
endpackage

// File: rtl/ocd_regmem_table.sv
// register/memory and read/modify/write lower-nibble operation tables
`timescale 1ns/10ps
module ocd_regmem_table
  import ocd_pkg::*;
(
  input wire logic [3:0] lo_nib_in,
  output ocd_op_type regmem_op_out,
  output ocd_op_type rmw_op_out
);
  // register/memory operation select
  always_comb begin
    case (lo_nib_in)
      4'h0: regmem_op_out = OCD_OP_SUB;
      4'h1: regmem_op_out = OCD_OP_CMPA;
      4'h2: regmem_op_out = OCD_OP_SBC;
      4'h3: regmem_op_out = OCD_OP_CMPX;
      4'h4: regmem_op_out = OCD_OP_AND;
      4'h5: regmem_op_out = OCD_OP_BIT;
      4'h6: regmem_op_out = OCD_OP_LDA;
      4'h7: regmem_op_out = OCD_OP_STA;
      4'h8: regmem_op_out = OCD_OP_EOR;
      4'h9: regmem_op_out = OCD_OP_ADC;
      4'hA: regmem_op_out = OCD_OP_ORA;
      4'hB: regmem_op_out = OCD_OP_ADD;
      4'hC: regmem_op_out = OCD_OP_JMP;
      4'hD: regmem_op_out = OCD_OP_JSR;
      4'hE: regmem_op_out = OCD_OP_LDX;
      default: regmem_op_out = OCD_OP_STX;
    endcase
  end
  // read/modify/write operation select; holes 1,2,5,B,E are undefined
  always_comb begin
    case (lo_nib_in)
      4'h0: rmw_op_out = OCD_OP_NEG;
      4'h3: rmw_op_out = OCD_OP_COM;
      4'h4: rmw_op_out = OCD_OP_LSR;
      4'h6: rmw_op_out = OCD_OP_ROR;
      4'h7: rmw_op_out = OCD_OP_ASR;
      4'h8: rmw_op_out = OCD_OP_LSL;
      4'h9: rmw_op_out = OCD_OP_ROL;
      4'hA: rmw_op_out = OCD_OP_DEC;
      4'hC: rmw_op_out = OCD_OP_INC;
      4'hD: rmw_op_out = OCD_OP_TST;
      4'hF: rmw_op_out = OCD_OP_CLR;
      default: rmw_op_out = OCD_OP_UNDEF;
    endcase
  end
endmodule

// File: rtl/ocd_addr_former.sv
// effective address former from mode, operand bytes and index register
`timescale 1ns/10ps
module ocd_addr_former
  import ocd_pkg::*;
(
  input wire ocd_mode_type mode_in,
  input wire logic [7:0] byte1_in,
  input wire logic [7:0] byte2_in,
  input wire logic [7:0] index_in,
  output logic [15:0] addr_out
);
  // high byte zero keeps direct and no-offset indexed inside the lowest 256 bytes; 8-bit offset indexed reaches 01FE
  always_comb begin
    case (mode_in)
      OCD_MODE_DIR, OCD_MODE_BSC, OCD_MODE_BTB: addr_out = {8'h00, byte1_in};
      OCD_MODE_EXT: addr_out = {byte1_in, byte2_in};
      OCD_MODE_IX0: addr_out = {8'h00, index_in};
      OCD_MODE_IX1: addr_out = 16'({8'h00, byte1_in} + {8'h00, index_in});
      OCD_MODE_IX2: addr_out = 16'({byte1_in, byte2_in} + {8'h00, index_in});
      default: addr_out = 16'h0000;
    endcase
  end
endmodule

// File: sim/ocd_prog_mem.sv
// program and data memory model on the decoder's fetch side
`timescale 1ns/10ps
module ocd_prog_mem (
  input wire logic [15:0] addr_in,
  input wire logic [7:0] data_addr_in,
  output logic [7:0] opcode_out,
  output logic [7:0] byte1_out,
  output logic [7:0] byte2_out,
  output logic [7:0] tested_out
);
  logic [7:0] rom [0:65535];
  // operand bytes follow the counter; the counter wraps at the top of memory
  assign opcode_out = rom[addr_in];
  assign byte1_out = rom[addr_in + 16'h0001];
  assign byte2_out = rom[addr_in + 16'h0002];
  // bit operands always live in the lowest page, so only the low byte is used
  assign tested_out = rom[{8'h00, data_addr_in}];
endmodule

// File: sim/mcu_opcode_decode_and_timing_tb.sv
// self-checking bench for the opcode decoder
`timescale 1ns/10ps
module mcu_opcode_decode_and_timing_tb;
  import ocd_pkg::*;
  logic CLK_IN = 1'b0;
  logic RESET_IN = 1'b1;
  logic DECODE = 1'b0;
  logic [15:0] pc = 16'h0100;
  logic [7:0] OPC, B1, B2, TB, BO;
  logic [15:0] EA, NPC;
  logic [3:0] CYC, CND;
  logic [2:0] BN;
  logic [1:0] LEN;
  logic VLD, CRY, WB, UND;
  ocd_group_type GRP;
  ocd_mode_type MD;
  ocd_op_type OP;
  int n_fail = 0;
  int n_checks = 0;
  // expected figures per register/memory column A..F
  logic [3:0] cyb [6] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h4, 4'h3};
  logic [1:0] lnb [6] = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h1};
  logic [15:0] eab [6] = '{16'h0, 16'h0012, 16'h1234, 16'h1324, 16'h0102, 16'h00F0};
  ocd_mode_type mdb [6] = '{OCD_MODE_IMM, OCD_MODE_DIR, OCD_MODE_EXT, OCD_MODE_IX2,
    OCD_MODE_IX1, OCD_MODE_IX0};
  ocd_op_type rmop [16] = '{OCD_OP_SUB, OCD_OP_CMPA, OCD_OP_SBC, OCD_OP_CMPX, OCD_OP_AND,
    OCD_OP_BIT, OCD_OP_LDA, OCD_OP_STA, OCD_OP_EOR, OCD_OP_ADC, OCD_OP_ORA, OCD_OP_ADD,
    OCD_OP_JMP, OCD_OP_JSR, OCD_OP_LDX, OCD_OP_STX};
  // holes in the modify/write rows are undefined
  ocd_op_type rwop [16] = '{OCD_OP_NEG, OCD_OP_UNDEF, OCD_OP_UNDEF, OCD_OP_COM, OCD_OP_LSR,
    OCD_OP_UNDEF, OCD_OP_ROR, OCD_OP_ASR, OCD_OP_LSL, OCD_OP_ROL, OCD_OP_DEC, OCD_OP_UNDEF,
    OCD_OP_INC, OCD_OP_TST, OCD_OP_UNDEF, OCD_OP_CLR};
  // rows 3..7 of modify/write
  ocd_mode_type rwmd [5] = '{OCD_MODE_DIR, OCD_MODE_INHA, OCD_MODE_INHX, OCD_MODE_IX1,
    OCD_MODE_IX0};
  logic [3:0] rwcy [5] = '{4'h5, 4'h3, 4'h3, 4'h6, 4'h5};
  logic [15:0] rwea [5] = '{16'h0012, 16'h0, 16'h0, 16'h0102, 16'h00F0};
  logic [7:0] copc [13] = '{8'h97, 8'h9F, 8'h99, 8'h98, 8'h9B, 8'h9A, 8'h83, 8'h81, 8'h80,
    8'h9C, 8'h9D, 8'h8E, 8'h8F};
  ocd_op_type cop [13] = '{OCD_OP_TAX, OCD_OP_TXA, OCD_OP_SEC, OCD_OP_CLC, OCD_OP_SEI,
    OCD_OP_CLI, OCD_OP_SWI, OCD_OP_RTS, OCD_OP_RTI, OCD_OP_RSP, OCD_OP_NOP, OCD_OP_STOP,
    OCD_OP_WAIT};
  logic [3:0] ccy [13] = '{4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'hA, 4'h6, 4'h9, 4'h2, 4'h2,
    4'h2, 4'h2};
  ////////////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  always #20 CLK_IN = ~CLK_IN;
  ocd_prog_mem mem (.addr_in(pc), .data_addr_in(B1), .opcode_out(OPC), .byte1_out(B1),
    .byte2_out(B2), .tested_out(TB));
  ocd_decoder dut (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .DECODE_IN(DECODE),
    .OPCODE_IN(OPC), .BYTE1_IN(B1), .BYTE2_IN(B2), .INDEX_IN(8'hF0),
    .PROGRAM_COUNTER_IN(pc), .TESTED_BYTE_IN(TB), .VALID_OUT(VLD), .GROUP_OUT(GRP),
    .MODE_OUT(MD), .OP_OUT(OP), .LENGTH_OUT(LEN), .CYCLES_OUT(CYC),
    .EFFECTIVE_ADDRESS_OUT(EA), .NEXT_PROGRAM_COUNTER_OUT(NPC), .BRANCH_OFFSET_OUT(BO),
    .BRANCH_COND_OUT(CND), .BIT_NUM_OUT(BN), .CARRY_FROM_BIT_OUT(CRY),
    .WRITE_BACK_OUT(WB), .UNDEFINED_OUT(UND));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk_dec(input ocd_group_type g, input ocd_op_type o, input logic [1:0] ln,
      input logic [3:0] cy);
    chk("valid", 16'h1, {15'h0, VLD});
    chk("group", {13'h0, g}, {13'h0, GRP});
    chk("op", {10'h0, o}, {10'h0, OP});
    chk("length", {14'h0, ln}, {14'h0, LEN});
    chk("cycles", {12'h0, cy}, {12'h0, CYC});
    chk("next_pc", pc + {14'h0, ln}, NPC);
    chk("undefined", {15'h0, g == OCD_GRP_UNDEF}, {15'h0, UND});
  endtask
  // places one instruction in memory and holds the request for one edge; calls chain
  // back to back so the decoder sees a new request on every edge
  task step(input logic [7:0] o, input logic [7:0] b1, input logic [7:0] b2);
    pc = pc + 16'h0004;
    mem.rom[pc] = o;
    mem.rom[pc + 16'h0001] = b1;
    mem.rom[pc + 16'h0002] = b2;
    DECODE = 1'b1;
    @(negedge CLK_IN);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regmem;
    logic [3:0] h, l;
    for (int i = 0; i < 96; i++) begin
      h = 4'(10 + i / 16);
      l = i[3:0];
      if (h == 4'hA && (l == 4'h7 || l == 4'hC || l == 4'hD || l == 4'hF)) continue;
      step({h, l}, 8'h12, 8'h34);
      chk_dec(OCD_GRP_REGMEM, rmop[l], lnb[i / 16], cyb[i / 16] + 4'(l == 4'h7 || l == 4'hF)
        - 4'(l == 4'hC) + 4'(l == 4'hD) * 4'h2);
      chk("mode", {12'h0, mdb[i / 16]}, {12'h0, MD});
      if (h != 4'hA) chk("ea", eab[i / 16], EA);
      chk("write_back", {15'h0, l == 4'h7 || l == 4'hF}, {15'h0, WB});
    end
  endtask
  task automatic t_rmw;
    logic [3:0] l;
    logic m;
    for (int i = 0; i < 80; i++) begin
      l = i[3:0];
      m = (i / 16 != 1) && (i / 16 != 2);
      step({4'(3 + i / 16), l}, 8'h12, 8'h34);
      if (rwop[l] == OCD_OP_UNDEF) chk_dec(OCD_GRP_UNDEF, OCD_OP_UNDEF, 2'h1, 4'h2);
      else begin
        chk_dec(OCD_GRP_RMW, rwop[l], 2'(1 + 32'(i / 16 == 0 || i / 16 == 3)),
          rwcy[i / 16] - 4'(m && l == 4'hD));
        chk("mode", {12'h0, rwmd[i / 16]}, {12'h0, MD});
        if (m) chk("ea", rwea[i / 16], EA);
        chk("write_back", {15'h0, l != 4'hD}, {15'h0, WB});
      end
    end
  endtask
  task automatic t_bits;
    mem.rom[16'h0045] = 8'hA5;
    for (int i = 0; i < 32; i++) begin
      step(8'(i), 8'h45, 8'h7E);
      if (i[4]) chk_dec(OCD_GRP_BITSC, i[0] ? OCD_OP_CLEAR_BIT_OP : OCD_OP_SET_BIT_OP, 2'h2, 4'h5);
      else begin
        chk_dec(OCD_GRP_BITTB, i[0] ? OCD_OP_BRANCH_IF_BIT_CLEAR : OCD_OP_BRANCH_IF_BIT_SET, 2'h3, 4'h5);
        chk("carry", {15'h0, 1'(8'hA5 >> i[3:1])}, {15'h0, CRY});
        chk("offset", 16'h007E, {8'h0, BO});
      end
      chk("bit_num", {13'h0, i[3:1]}, {13'h0, BN});
      chk("ea", 16'h0045, EA);
    end
  endtask
  task automatic t_branch;
    for (int i = 0; i < 16; i++) begin
      step(8'(32 + i), 8'h9C, 8'h00);
      chk_dec(OCD_GRP_BRANCH, OCD_OP_BRANCH, 2'h2, 4'h3);
      chk("cond", 16'(i), {12'h0, CND});
      chk("offset", 16'h009C, {8'h0, BO});
    end
    step(8'hAD, 8'h9C, 8'h00);
    chk("bsr_op", {10'h0, OCD_OP_BSR}, {10'h0, OP});
    chk("bsr_cycles", 16'h0006, {12'h0, CYC});
    chk("bsr_length", 16'h0002, {14'h0, LEN});
  endtask
  task automatic t_ctrl;
    int k;
    for (int o = 128; o < 160; o++) begin
      k = -1;
      for (int j = 0; j < 13; j++) if (copc[j] == 8'(o)) k = j;
      step(8'(o), 8'h00, 8'h00);
      if (k < 0) chk_dec(OCD_GRP_UNDEF, OCD_OP_UNDEF, 2'h1, 4'h2);
      else chk_dec(OCD_GRP_CTRL, cop[k], 2'h1, ccy[k]);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // watchdog: the whole sequence needs well under 1000 cycles
  initial begin
    #400000;
    n_fail++;
    results;
  end
  // main sequence; reset figures checked while reset is still held
  initial begin
    repeat (6) @(negedge CLK_IN);
    chk("rst_valid", 16'h0, {15'h0, VLD});
    chk("rst_undef", 16'h1, {15'h0, UND});
    chk("rst_length", 16'h1, {14'h0, LEN});
    RESET_IN = 1'b0;
    @(negedge CLK_IN);
    t_regmem;
    t_rmw;
    t_bits;
    t_branch;
    t_ctrl;
    DECODE = 1'b0;
    @(negedge CLK_IN);
    chk("valid_drop", 16'h0, {15'h0, VLD});
    results;
  end
endmodule
